// >>> verilog/spp_pkg.sv
package spp_pkg;

  // Serial command and shift register sizes
  localparam int unsigned CMD_W     = 5;
  localparam int unsigned ROW_N     = 16;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned ID_W      = 8;
  localparam int unsigned FIFO_W    = ROW_N + DATA_W;
  localparam int unsigned FIFO_D    = 16;
  localparam int unsigned DED_N     = 3;

  // Dedicated input positions while programming is off
  localparam int unsigned DED_IN0   = 0;
  localparam int unsigned DED_IN1   = 1;
  localparam int unsigned DED_IN2   = 2;

  // Device identifier, value arbitrary
  localparam logic [ID_W-1:0] DEVICE_ID = 8'h5a;

  // Commands shifted in after the command entry step
  localparam logic [CMD_W-1:0] CMD_NOP       = 5'h00;
  localparam logic [CMD_W-1:0] CMD_ADDR_SH   = 5'h01;
  localparam logic [CMD_W-1:0] CMD_DATA_SH   = 5'h02;
  localparam logic [CMD_W-1:0] CMD_PROGRAM   = 5'h07;
  localparam logic [CMD_W-1:0] CMD_VERIFY    = 5'h0a;
  localparam logic [CMD_W-1:0] CMD_READ_ID   = 5'h16;

  // Reset values
  localparam logic [CMD_W-1:0]  CMD_RST  = 5'h00;
  localparam logic [ROW_N-1:0]  ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [DED_N-1:0]  DED_RST  = 3'h0;

  typedef enum logic [1:0] {
    SPP_IDLE,
    SPP_CMD,
    SPP_EXEC
  } spp_state_t;

  // One programmed configuration word: row mask and data
  typedef struct packed {
    logic [ROW_N-1:0]  rows;
    logic [DATA_W-1:0] data;
  } spp_cfg_t;

endpackage

// >>> verilog/spp_port.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Programming functions work only while the enable pin is held low.
// - Serial data in is dedicated input 0 when enable is high, else data.
// - Serial data in together with mode steers the programming machine.
// - Mode is dedicated input 2 when enable is high, else machine control.
// - Serial data out is dedicated input 1 when enable is high, else driven.
// - Four programming signals feed one on-chip sequencing machine, which drives serial data out.
// - An eight-bit identifier is shifted out on the read identifier command.
// - A one in an address bit enables that row, a zero disables it.
// - Configuration is loaded only serially and kept in the cell array.
// - Serial clock is clock input 2 when enable is high, else shift clock.

module spp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // spp_fifo

module spp_port (
  input  wire logic                   clk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   sclk_i,
  input  wire logic                   prog_enable_n_i,
  input  wire logic                   serial_prog_in_i,
  input  wire logic                   mode_i,
  input  wire logic                   serial_prog_out_i,
  output logic                        serial_prog_out_o,
  output logic                        serial_prog_out_oe_n_o,
  output logic [spp_pkg::DED_N-1:0]   ded_in_o,
  output logic                        global_clock_2_o,
  output logic                        prog_active_o,
  output spp_pkg::spp_cfg_t           cfg_o,
  output logic                        cfg_valid_o,
  input  wire logic                   cfg_ready_i
);
  import spp_pkg::*;

  // Link domain (serial clock)
  spp_state_t        st_q;
  logic [CMD_W-1:0]  cmd_q;
  logic [ROW_N-1:0]  addr_q;
  logic [DATA_W-1:0] data_q;
  logic [DATA_W-1:0] cell_q [ROW_N];
  logic [DATA_W-1:0] rows_rd;
  logic              en_l1_q;
  logic              en_l2_q;
  logic              sdo_q;
  logic              req_q;
  spp_cfg_t          pay_q;
  logic              ack_l1_q;
  logic              ack_l2_q;
  logic              busy;
  logic              prog_go;
  logic              step;
  logic              refused_q;

  // System domain
  logic              en_s1_q;
  logic              en_s2_q;
  logic [DED_N-1:0]  pin_s1_q;
  logic [DED_N-1:0]  pin_s2_q;
  logic              ck_s1_q;
  logic              ck_s2_q;
  logic              req_s1_q;
  logic              req_s2_q;
  logic              ack_q;
  logic              fifo_ready;
  logic              fifo_valid;
  spp_cfg_t          fifo_data;
  logic              pend;
  logic              take;

  // Programming enable seen in the link domain
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_l1_q <= 1'b0;
      en_l2_q <= 1'b0;
    end else begin
      en_l1_q <= !prog_enable_n_i;
      en_l2_q <= en_l1_q;
    end
  end

  assign step    = en_l2_q && mode_i;
  assign busy    = (req_q != ack_l2_q);
  assign prog_go = en_l2_q && (st_q == SPP_CMD) && mode_i
                   && !serial_prog_in_i && (cmd_q == CMD_PROGRAM)
                   && !busy;

  // Sequencing machine steered by mode and serial data in
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= SPP_IDLE;
    end else if (!en_l2_q) begin
      st_q <= SPP_IDLE;
    end else begin
      case (st_q)
        SPP_IDLE: begin
          if (step && serial_prog_in_i) begin
            st_q <= SPP_CMD;
          end
        end
        SPP_CMD: begin
          if (step) begin
            st_q <= serial_prog_in_i ? SPP_IDLE : SPP_EXEC;
          end
        end
        SPP_EXEC: begin
          if (step) begin
            st_q <= SPP_IDLE;
          end
        end
        default: st_q <= SPP_IDLE;
      endcase
    end
  end

  // Command register
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_q <= CMD_RST;
    end else if (en_l2_q && (st_q == SPP_IDLE) && step) begin
      cmd_q <= CMD_RST;
    end else if (en_l2_q && (st_q == SPP_CMD) && !mode_i) begin
      cmd_q <= {cmd_q[CMD_W-2:0], serial_prog_in_i};
    end
  end

  // Address shift register
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_q <= ADDR_RST;
    end else if (en_l2_q && (st_q == SPP_EXEC) && !mode_i
                 && (cmd_q == CMD_ADDR_SH)) begin
      addr_q <= {serial_prog_in_i, addr_q[ROW_N-1:1]};
    end
  end

  // Read-back of every enabled row, ORed
  always_comb begin
    rows_rd = DATA_RST;
    for (int r = 0; r < ROW_N; r++) begin
      if (addr_q[r]) begin
        rows_rd = rows_rd | cell_q[r];
      end
    end
  end

  // Data shift register, also loaded for verify and identifier
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_q <= DATA_RST;
    end else if (en_l2_q && (st_q == SPP_CMD) && step
                 && !serial_prog_in_i) begin
      if (cmd_q == CMD_READ_ID) begin
        data_q <= {{(DATA_W-ID_W){1'b0}}, DEVICE_ID};
      end else if (cmd_q == CMD_VERIFY) begin
        data_q <= rows_rd;
      end
    end else if (en_l2_q && (st_q == SPP_EXEC) && !mode_i
                 && (cmd_q != CMD_ADDR_SH) && (cmd_q != CMD_PROGRAM)) begin
      data_q <= {serial_prog_in_i, data_q[DATA_W-1:1]};
    end
  end

  // Configuration cells, written only by the program command
  always_ff @(posedge sclk_i) begin
    if (prog_go) begin
      for (int r = 0; r < ROW_N; r++) begin
        if (addr_q[r]) begin
          cell_q[r] <= data_q;
        end
      end
    end
  end

  // Refusal of the latest program step, shown during its execute step
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      refused_q <= 1'b0;
    end else if (!en_l2_q) begin
      refused_q <= 1'b0;
    end else if ((st_q == SPP_CMD) && step && !serial_prog_in_i
                 && (cmd_q == CMD_PROGRAM)) begin
      refused_q <= busy;
    end
  end

  // Serial output follows the selected register or the refusal flag
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sdo_q <= 1'b0;
    end else if (st_q == SPP_EXEC && cmd_q == CMD_ADDR_SH) begin
      sdo_q <= addr_q[0];
    end else if (st_q == SPP_EXEC && cmd_q == CMD_PROGRAM) begin
      sdo_q <= refused_q;
    end else begin
      sdo_q <= data_q[0];
    end
  end

  // Toggle request carrying each programmed word to the system side
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_q    <= 1'b0;
      pay_q    <= '0;
      ack_l1_q <= 1'b0;
      ack_l2_q <= 1'b0;
    end else begin
      ack_l1_q <= ack_q;
      ack_l2_q <= ack_l1_q;
      if (prog_go) begin
        req_q      <= !req_q;
        pay_q.rows <= addr_q;
        pay_q.data <= data_q;
      end
    end
  end

  assign serial_prog_out_o = sdo_q;

  // Pins brought into the system clock domain
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_s1_q  <= 1'b0;
      en_s2_q  <= 1'b0;
      pin_s1_q <= DED_RST;
      pin_s2_q <= DED_RST;
      ck_s1_q  <= 1'b0;
      ck_s2_q  <= 1'b0;
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else begin
      en_s1_q  <= !prog_enable_n_i;
      en_s2_q  <= en_s1_q;
      pin_s1_q <= {mode_i, serial_prog_out_i, serial_prog_in_i};
      pin_s2_q <= pin_s1_q;
      ck_s1_q  <= sclk_i;
      ck_s2_q  <= ck_s1_q;
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
    end
  end

  // Dual-function pins as dedicated inputs while programming is off
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ded_in_o               <= DED_RST;
      global_clock_2_o       <= 1'b0;
      prog_active_o          <= 1'b0;
      serial_prog_out_oe_n_o <= 1'b1;
    end else begin
      ded_in_o               <= en_s2_q ? DED_RST : pin_s2_q;
      global_clock_2_o       <= en_s2_q ? 1'b0 : ck_s2_q;
      prog_active_o          <= en_s2_q;
      serial_prog_out_oe_n_o <= !en_s2_q;
    end
  end

  assign pend = (req_s2_q != ack_q);
  assign take = pend && fifo_ready;

  // Acknowledge only once the word is in the buffer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
    end else if (take) begin
      ack_q <= req_s2_q;
    end
  end

  spp_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_data_i   (pay_q),
    .in_valid_i  (pend),
    .in_ready_o  (fifo_ready),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (!cfg_valid_o || cfg_ready_i)
  );

  // Output stage for the configuration stream
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_o       <= '0;
      cfg_valid_o <= 1'b0;
    end else if (!cfg_valid_o || cfg_ready_i) begin
      cfg_o       <= fifo_data;
      cfg_valid_o <= fifo_valid;
    end
  end
endmodule // spp_port

// >>> bench/spp_port_chk.sv
`timescale 1ns/10ps
module spp_port_chk (
  input wire logic                 clk_i,
  input wire logic                 resetn_i,
  input wire logic                 sclk_i,
  input wire logic                 prog_enable_n_i,
  input wire logic                 serial_prog_in_i,
  input wire logic                 mode_i,
  input wire logic                 serial_prog_out_i,
  input wire logic                 serial_prog_out_o,
  input wire logic                 serial_prog_out_oe_n_o,
  input wire logic [spp_pkg::DED_N-1:0] ded_in_o,
  input wire logic                 global_clock_2_o,
  input wire logic                 prog_active_o,
  input wire spp_pkg::spp_cfg_t    cfg_o,
  input wire logic                 cfg_valid_o,
  input wire logic                 cfg_ready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  ded_follow_a: assert property (
    (prog_enable_n_i && $stable({mode_i, serial_prog_out_i,
    serial_prog_in_i}))[*4] |-> ded_in_o == {mode_i, serial_prog_out_i,
    serial_prog_in_i}) else $error("dedicated inputs wrong");
  ded_quiet_a: assert property (
    (!prog_enable_n_i)[*4] |-> ded_in_o == 3'h0 && !global_clock_2_o)
    else $error("dedicated outputs not quiet");
  gclk_follow_a: assert property (
    (prog_enable_n_i && $stable(sclk_i))[*4] |->
    global_clock_2_o == sclk_i) else $error("clock input wrong");
  oe_release_a: assert property (
    prog_enable_n_i[*4] |-> serial_prog_out_oe_n_o)
    else $error("data out driven");
  oe_drive_a: assert property (
    (!prog_enable_n_i)[*4] |-> !serial_prog_out_oe_n_o)
    else $error("data out not driven");
  mode_flag_a: assert property (
    $stable(prog_enable_n_i)[*4] |-> prog_active_o != prog_enable_n_i)
    else $error("programming flag wrong");
  word_hold_a: assert property (
    cfg_valid_o && !cfg_ready_i |=> cfg_valid_o)
    else $error("word dropped");
  word_stable_a: assert property (
    cfg_valid_o && !cfg_ready_i |=> $stable(cfg_o))
    else $error("word changed");
endmodule // spp_port_chk

// >>> bench/spp_prog_model.sv
`timescale 1ns/10ps
module spp_prog_model (
  input  wire logic sdo_i,
  input  wire logic oe_n_i,
  output logic      sclk_o,
  output logic      en_n_o,
  output logic      sdi_o,
  output logic      mode_o,
  output logic      pin_o
);
  logic drv;
  // Pin level: our drive while enable is high, the device's while it
  // drives, and a wrong level when the device leaves it floating
  assign pin_o = !oe_n_i ? sdo_i : (en_n_o ? drv : !sdo_i);
  initial begin
    sclk_o = 1'b0;
    en_n_o = 1'b1;
    sdi_o  = 1'b0;
    mode_o = 1'b0;
    drv    = 1'b0;
  end
  // One serial clock cycle, data only moves while the clock is low
  task automatic step(input logic m, input logic d, output logic q);
    mode_o = m;
    sdi_o = d;
    #7.5 sclk_o = 1'b1;
    #7.5 sclk_o = 1'b0;
    q = pin_o;
  endtask
endmodule // spp_prog_model

// >>> bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import spp_pkg::*;
  logic             clk_i = 1'b0;
  logic             resetn_i = 1'b0;
  logic             cfg_ready_i = 1'b0;
  logic             hold = 1'b1;
  logic             sclk_i, prog_enable_n_i, serial_prog_in_i, mode_i;
  logic             serial_prog_out_i, serial_prog_out_o;
  logic             serial_prog_out_oe_n_o, global_clock_2_o;
  logic             prog_active_o, cfg_valid_o, q;
  logic [DED_N-1:0] ded_in_o;
  logic [15:0]      rd, rows, ld;
  logic [31:0]      wd;
  spp_cfg_t         cfg_o;
  spp_cfg_t         exp_q[$];
  int               n_fail = 0, cmp_count = 0, acc = 0, rej = 0;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) cfg_ready_i <= hold ? 1'b0 : 1'($urandom);

  spp_prog_model pm (.sdo_i(serial_prog_out_o),
    .oe_n_i(serial_prog_out_oe_n_o), .sclk_o(sclk_i),
    .en_n_o(prog_enable_n_i), .sdi_o(serial_prog_in_i), .mode_o(mode_i),
    .pin_o(serial_prog_out_i));
  spp_port uut (.clk_i, .resetn_i, .sclk_i, .prog_enable_n_i,
    .serial_prog_in_i, .mode_i, .serial_prog_out_i, .serial_prog_out_o,
    .serial_prog_out_oe_n_o, .ded_in_o, .global_clock_2_o, .prog_active_o,
    .cfg_o, .cfg_valid_o, .cfg_ready_i);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [CMD_W-1:0] c);
    pm.step(1'b1, 1'b1, q);
    for (int i = CMD_W-1; i >= 0; i--) pm.step(1'b0, c[i], q);
    pm.step(1'b1, 1'b0, q);
  endtask
  task automatic shift(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      pm.step(1'b0, v[i], q);
      rd[i] = q;
    end
    pm.step(1'b1, 1'b0, q);
  endtask
  task automatic prog(input logic [15:0] d);
    cmd(CMD_DATA_SH);
    shift(d, 16);
    cmd(CMD_PROGRAM);
    shift(16'h0, 1);
    ld = d;
    if (rd[0] === 1'b0) begin
      exp_q.push_back({rows, d});
      acc++;
    end else rej++;
  endtask
  task automatic drain();
    hold = 1'b0;
    for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge clk_i);
    chk(32'(exp_q.size()), 32'h0);
    hold = 1'b1;
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Stream monitor: each accepted word against the oldest note
  always @(posedge clk_i) begin
    if (cfg_valid_o === 1'b1 && cfg_ready_i === 1'b1)
      chk(cfg_o, exp_q.size() ? exp_q.pop_front() : 32'hx);
  end

  initial begin
    #200000;
    n_fail++;
    final_report();
  end

  initial begin
    void'($urandom(32'h682a557b));
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (8) begin
      wd = $urandom;
      @(posedge clk_i);
      pm.sdi_o <= wd[0];
      pm.drv <= wd[1];
      pm.mode_o <= wd[2];
      pm.sclk_o <= wd[3];
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
      chk({ded_in_o, global_clock_2_o, prog_active_o,
        serial_prog_out_oe_n_o}, {wd[2:0], wd[3], 2'b01});
    end
    $display("test dedicated done");
    @(posedge clk_i);
    pm.en_n_o <= 1'b0;
    pm.sclk_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    chk({ded_in_o, global_clock_2_o, prog_active_o,
      serial_prog_out_oe_n_o}, 32'h2);
    pm.step(1'b0, 1'b0, q);
    pm.step(1'b0, 1'b0, q);
    cmd(CMD_READ_ID);
    shift(16'h0, ID_W);
    chk(32'(rd[ID_W-1:0]), 32'(DEVICE_ID));
    $display("test identifier done");
    rows = 16'($urandom) | 16'h1;
    cmd(CMD_ADDR_SH);
    shift(rows, 16);
    repeat (3) prog(16'($urandom));
    drain();
    cmd(CMD_VERIFY);
    shift(16'h0, 16);
    chk(32'(rd), 32'(ld));
    cmd(CMD_ADDR_SH);
    shift(16'h0, 16);
    cmd(CMD_VERIFY);
    shift(16'h0, 16);
    chk(32'(rd), 32'h0);
    $display("test program verify done");
    rows = 16'($urandom);
    cmd(CMD_ADDR_SH);
    shift(rows, 16);
    acc = 0;
    repeat (20) prog(16'($urandom));
    chk(32'(acc > 0 && rej > 0), 32'h1);
    drain();
    $display("test full stream done");
    final_report();
  end
endmodule // testbench

bind spp_port spp_port_chk chk_i (.clk_i, .resetn_i, .sclk_i,
  .prog_enable_n_i, .serial_prog_in_i, .mode_i, .serial_prog_out_i,
  .serial_prog_out_o, .serial_prog_out_oe_n_o, .ded_in_o, .global_clock_2_o,
  .prog_active_o, .cfg_o, .cfg_valid_o, .cfg_ready_i);
